// [rtl/config_store.sv]
// Purpose: Nonvolatile image of the two configuration bytes
// Assumes: Image survives rst_b; only por_b reinitialises it
// Notes:   Flip-flop model of the configuration storage
`timescale 1ns/100ps
module config_store
  import sensor_cfg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       por_b,
  input  wire logic       save,
  input  wire logic [7:0] save_one,
  input  wire logic [7:0] save_two,
  output logic      [7:0] stored_one,
  output logic      [7:0] stored_two
);
  always_ff @(posedge clk_sys) begin
    if (!por_b) begin
      stored_one <= RST_CONFIG_ONE;
      stored_two <= RST_CONFIG_TWO;
    end else if (save) begin
      stored_one <= save_one;
      stored_two <= save_two & ~ADDR_SRC_MASK;
    end
  end
endmodule

// [rtl/cycle_timer.sv]
// Purpose: Loadable down counter giving a one-cycle expiry pulse
// Assumes: load has priority over counting
// Notes:   Count of zero expires on the next edge
`timescale 1ns/100ps
module cycle_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  output logic             expired
);
  logic [31:0] count;
  logic        running;
  wire         at_end = running && (count == 32'h0);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count   <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= at_end && !load;
      if (load) begin
        count   <= load_value;
        running <= 1'b1;
      end else if (at_end) begin
        running <= 1'b0;
      end else if (running) begin
        count <= count - 32'h1;
      end
    end
  end
endmodule

// [rtl/sensor_cfg_pkg.sv]
// Purpose: Constants for the sensor configuration register bank
// Assumes: 100 MHz system clock, byte-wide scratch area writes
// Notes:   Rules summary follows
// Functional notes
// - Bit 7 selects 12 or 16-bit format
// - Bit 5 selects 3 ms or 5.5 ms
// - Bit 4 alert latch/comparator, supply only
// - Bit 3 averages eight conversions
// - Bus code 000 one-shot, 010 automatic
// - Bus code 001 stacked, staggered by address
// - Supply codes give periods 8 s to 0.125 s
// - Copy saves config two except address source
// - Lock applies fast speed after checksum read
// - Config one restored at power-on
// - Fast speed cleared by standard reset, or by a restore from an image with bit 7 clear
// - Address source acts on field change
// - Lock sticks and blocks protected writes
package sensor_cfg_pkg;
  localparam logic [7:0] OFS_CONFIG_ONE   = 8'h04;
  localparam logic [7:0] OFS_CONFIG_TWO   = 8'h05;
  localparam logic [7:0] OFS_SHORT_ADDR   = 8'h06;
  localparam logic [7:0] OFS_OFFSET_LO    = 8'h08;
  localparam logic [7:0] RST_CONFIG_ONE   = 8'h70;
  localparam logic [7:0] RST_CONFIG_TWO   = 8'h80;
  localparam int         BIT_FORMAT       = 7;
  localparam int         BIT_RESERVED     = 6;
  localparam int         BIT_DURATION     = 5;
  localparam int         BIT_ALERT_MODE   = 4;
  localparam int         BIT_AVERAGE      = 3;
  localparam int         BIT_FAST         = 7;
  localparam int         BIT_LOCK         = 0;
  localparam int         SCHED_MSB        = 2;
  localparam int         ADDR_SRC_LSB     = 5;
  localparam logic [7:0] ADDR_SRC_MASK    = 8'h60;
  localparam logic [7:0] LOCK_FIXED_MASK  = 8'h81;
  localparam logic [2:0] SCHED_ONE_SHOT   = 3'h0;
  localparam logic [2:0] SCHED_STACKED    = 3'h1;
  localparam logic [2:0] SCHED_AUTO       = 3'h2;
  localparam logic [3:0] AVERAGE_COUNT    = 4'h8;
  localparam int         CLK_MHZ          = 100;
  localparam int         CONV_SHORT_US    = 3000;
  localparam int         CONV_LONG_US     = 5500;
  localparam int         CONV_SHORT_CYC   = CONV_SHORT_US * CLK_MHZ;
  localparam int         CONV_LONG_CYC    = CONV_LONG_US * CLK_MHZ;
  localparam int         PERIOD_MIN_MS    = 125;
  localparam int         PERIOD_MIN_CYC   = PERIOD_MIN_MS * 1000 * CLK_MHZ;
  localparam int         STAGGER_STEP_CYC = 1000;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_STAGGER = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DONE    = 4'b1000
  } conv_state_t;
endpackage

// [rtl/sensor_config_registers.sv]
// Purpose: Two configuration registers and the conversion scheduler they steer
// Assumes: Byte writes arrive from the bus engine on the same clock
// Notes:   Converter and alert logic lie outside; this block times them
`timescale 1ns/100ps
module sensor_config_registers
  import sensor_cfg_pkg::*;
#(
  parameter int CONV_SHORT_CYCLES = CONV_SHORT_CYC,
  parameter int CONV_LONG_CYCLES  = CONV_LONG_CYC,
  parameter int PERIOD_MIN_CYCLES = PERIOD_MIN_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       por_b,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       copy_cmd,
  input  wire logic       scratch_complete,
  input  wire logic       standard_reset,
  input  wire logic       convert_cmd,
  input  wire logic       bus_powered_pin,
  input  wire logic [7:0] short_address,
  output logic [7:0]      device_config_one,
  output logic [7:0]      device_config_two,
  output logic            result_format_select,
  output logic            conversion_duration_select,
  output logic            alert_comparator_mode,
  output logic            averaging_select,
  output logic [2:0]      conversion_schedule_select,
  output logic            fast_speed_enable,
  output logic [1:0]      short_address_source,
  output logic            address_source_changed,
  output logic            write_protect,
  output logic            protected_write_rejected,
  output logic            conversion_start,
  output logic            conversion_busy,
  output logic            conversion_done
);
  // ---------------------------------------------------------------
  // Power mode detection
  // ---------------------------------------------------------------
  logic bus_pwr_meta;
  logic bus_powered;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_pwr_meta <= 1'b1;
      bus_powered  <= 1'b1;
    end else begin
      bus_pwr_meta <= bus_powered_pin;
      bus_powered  <= bus_pwr_meta;
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [7:0] stored_one;
  logic [7:0] stored_two;
  logic       restore_pending;
  logic       fast_pending;
  logic [1:0] prev_addr_src;

  wire hit_one     = wr_en && (wr_addr == OFS_CONFIG_ONE);
  wire hit_two     = wr_en && (wr_addr == OFS_CONFIG_TWO);
  wire hit_guarded = wr_en && (wr_addr == OFS_CONFIG_ONE || wr_addr == OFS_CONFIG_TWO
                     || wr_addr == OFS_SHORT_ADDR || wr_addr >= OFS_OFFSET_LO);
  wire lock_set    = device_config_two[BIT_LOCK];
  wire accept_one  = hit_one && !lock_set;
  wire accept_two  = hit_two && !lock_set;
  // Host may only set fast speed
  wire fast_req    = wr_data[BIT_FAST] | device_config_two[BIT_FAST];
  // Fast speed held back while locking
  wire lock_now    = accept_two && wr_data[BIT_LOCK];
  wire fast_apply  = lock_now ? device_config_two[BIT_FAST] : fast_req;
  wire [7:0] next_two_write = {fast_apply, wr_data[BIT_FAST-1:0]};

  config_store u_store (
    .clk_sys    (clk_sys),
    .por_b      (por_b),
    .save       (copy_cmd),
    .save_one   (device_config_one),
    .save_two   (device_config_two),
    .stored_one (stored_one),
    .stored_two (stored_two)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      device_config_one <= RST_CONFIG_ONE;
      device_config_two <= RST_CONFIG_TWO;
      restore_pending   <= 1'b1;
      fast_pending      <= 1'b0;
    end else begin
      if (restore_pending && !por_b) begin
        restore_pending <= 1'b1;
      end else if (restore_pending) begin
        device_config_one <= stored_one;
        device_config_two <= (stored_two & ~ADDR_SRC_MASK)
                             | (device_config_two & ADDR_SRC_MASK);
        restore_pending   <= 1'b0;
      end else begin
        if (accept_one) begin
          device_config_one <= wr_data;
        end
        if (accept_two) begin
          device_config_two <= next_two_write;
          fast_pending      <= lock_now && wr_data[BIT_FAST];
        end else if (fast_pending && scratch_complete) begin
          device_config_two[BIT_FAST] <= 1'b1;
          fast_pending                <= 1'b0;
        end
      end
      // A speed reset leaves the bus at standard speed, so it beats a restore
      // Standard reset clears
      if (standard_reset) begin
        device_config_two[BIT_FAST] <= 1'b0;
        fast_pending                <= 1'b0;
      end
      if (!por_b) begin
        restore_pending <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address source change and write rejection
  // ---------------------------------------------------------------
  wire [1:0] addr_src_now = device_config_two[ADDR_SRC_LSB +: 2];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prev_addr_src            <= 2'h0;
      address_source_changed   <= 1'b0;
      protected_write_rejected <= 1'b0;
    end else begin
      prev_addr_src            <= addr_src_now;
      address_source_changed   <= (addr_src_now != prev_addr_src);
      protected_write_rejected <= hit_guarded && lock_set;
    end
  end

  assign write_protect        = lock_set;
  assign fast_speed_enable    = device_config_two[BIT_FAST];
  assign short_address_source = addr_src_now;

  // ---------------------------------------------------------------
  // Field outputs
  // ---------------------------------------------------------------
  // Result format
  assign result_format_select       = device_config_one[BIT_FORMAT];
  assign conversion_duration_select = device_config_one[BIT_DURATION];
  assign alert_comparator_mode      = device_config_one[BIT_ALERT_MODE] && !bus_powered;
  assign averaging_select           = device_config_one[BIT_AVERAGE];
  assign conversion_schedule_select = device_config_one[SCHED_MSB:0];

  // ---------------------------------------------------------------
  // Conversion scheduling
  // ---------------------------------------------------------------
  // Decode by power mode
  wire [2:0] sched      = conversion_schedule_select;
  wire       sup_period = !bus_powered && (sched != SCHED_ONE_SHOT);
  wire       bus_auto   = bus_powered && (sched == SCHED_AUTO);
  wire       bus_stack  = bus_powered && (sched == SCHED_STACKED);
  // Period doubles per lower code
  // Inverting a 3-bit code is the same as seven minus the code
  wire [2:0] period_shift = ~sched;
  wire [31:0] period_cycles = 32'(PERIOD_MIN_CYCLES) << period_shift;
  wire [31:0] conv_cycles = conversion_duration_select ? 32'(CONV_LONG_CYCLES)
                                                       : 32'(CONV_SHORT_CYCLES);
  wire [31:0] stagger_cycles = 32'(short_address) * 32'(STAGGER_STEP_CYC);

  conv_state_t state;
  conv_state_t next_state;
  logic [3:0]  avg_left;
  logic        period_expired;
  logic        step_expired;
  logic        period_armed;

  wire period_load = sup_period && !period_armed;
  wire step_load   = (state == ST_IDLE && bus_stack && convert_cmd)
                  || (state == ST_IDLE && !bus_stack && next_state == ST_CONVERT)
                  || (state == ST_STAGGER && step_expired)
                  || (state == ST_CONVERT && step_expired && avg_left > 4'h1);
  wire [31:0] step_value = (state == ST_IDLE && bus_stack) ? stagger_cycles : conv_cycles;

  cycle_timer u_period (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .load       (period_load || period_expired),
    .load_value (period_cycles),
    .expired    (period_expired)
  );

  cycle_timer u_step (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .load       (step_load),
    .load_value (step_value),
    .expired    (step_expired)
  );

  wire start_req = (convert_cmd && !bus_stack) || bus_auto
                   || (sup_period && period_expired);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (bus_stack && convert_cmd) begin
          next_state = ST_STAGGER;
        end else if (start_req) begin
          next_state = ST_CONVERT;
        end
      end
      ST_STAGGER: begin
        if (step_expired) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (step_expired && avg_left <= 4'h1) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      avg_left     <= 4'h1;
      period_armed <= 1'b0;
    end else begin
      state        <= next_state;
      period_armed <= sup_period;
      if (next_state == ST_CONVERT && state != ST_CONVERT) begin
        avg_left <= averaging_select ? AVERAGE_COUNT : 4'h1;
      end else if (state == ST_CONVERT && step_expired) begin
        avg_left <= avg_left - 4'h1;
      end
    end
  end

  assign conversion_start = (state != ST_CONVERT) && (next_state == ST_CONVERT);
  assign conversion_busy  = (state == ST_CONVERT) || (state == ST_STAGGER);
  assign conversion_done  = (state == ST_DONE);
endmodule

// [sim/host_model.sv]
// Purpose: Bus host controller issuing byte writes and command pulses
// Assumes: Signals change 1 ns after the rising edge
// Notes:   Released data shows the inverse of the last byte
`timescale 1ns/100ps
module host_model
  import sensor_cfg_pkg::*;
#(
  parameter int IDLE_CYC = 50
) (
  input  wire logic       clk_sys,
  output logic            wr_en,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            copy_cmd,
  output logic            scratch_complete,
  output logic            standard_reset,
  output logic            convert_cmd
);
  initial begin
    {wr_en, copy_cmd, scratch_complete, standard_reset, convert_cmd} = 5'h00;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == OFS_CONFIG_ONE) ? (d | 8'h40) : d;
    @(posedge clk_sys);
    #1 {wr_en, wr_addr, wr_data} = {1'b1, a, v};
    @(posedge clk_sys);
    #1 {wr_en, wr_data} = {1'b0, ~v};
    // idle while the address decode runs
    if (a == OFS_CONFIG_TWO && v[6:5] != 2'b00) repeat (IDLE_CYC) @(posedge clk_sys);
  endtask
  task automatic strobe(input int k);
    @(posedge clk_sys);
    #1 {copy_cmd, scratch_complete, standard_reset, convert_cmd} = 4'h8 >> k;
    @(posedge clk_sys);
    #1 {copy_cmd, scratch_complete, standard_reset, convert_cmd} = 4'h0;
  endtask
  // short address and config one before the lock byte takes hold
  task automatic send_scratch(input logic [7:0] c1, input logic [7:0] c2);
    wr(OFS_SHORT_ADDR, 8'h00);
    wr(OFS_CONFIG_ONE, c1);
    wr(OFS_CONFIG_TWO, c2);
  endtask
endmodule

// [sim/sensor_config_registers_chk.sv]
// Purpose: Port-level checks on the configuration register bank
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every instance of the bank
`timescale 1ns/100ps
module sensor_config_registers_chk
  import sensor_cfg_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       por_b,
  input wire logic       wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       standard_reset,
  input wire logic       scratch_complete,
  input wire logic       convert_cmd,
  input wire logic       bus_powered_pin,
  input wire logic [7:0] device_config_one,
  input wire logic       result_format_select,
  input wire logic       alert_comparator_mode,
  input wire logic       averaging_select,
  input wire logic [2:0] conversion_schedule_select,
  input wire logic       fast_speed_enable,
  input wire logic [1:0] short_address_source,
  input wire logic       address_source_changed,
  input wire logic       write_protect,
  input wire logic       protected_write_rejected,
  input wire logic       conversion_start,
  input wire logic       conversion_busy,
  input wire logic       conversion_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire cfg1_wr = wr_en && wr_addr == OFS_CONFIG_ONE;
  sequence s_launch;
    convert_cmd && !conversion_busy && conversion_schedule_select == SCHED_ONE_SHOT;
  endsequence
  sequence s_running;
    conversion_start ##1 conversion_busy[*3];
  endsequence
  a_field_view: assert property (
    result_format_select == device_config_one[BIT_FORMAT] &&
    averaging_select == device_config_one[BIT_AVERAGE] &&
    conversion_schedule_select == device_config_one[2:0]) else $error("field view wrong");
  a_alert_view: assert property (
    $past(rst_b) && $past(rst_b, 2) |-> alert_comparator_mode ==
    (device_config_one[BIT_ALERT_MODE] && !$past(bus_powered_pin, 2))) else $error("alert view");
  a_cfg_write: assert property (
    !write_protect && cfg1_wr && por_b && $past(rst_b) |=> device_config_one == $past(wr_data))
    else $error("config one write lost");
  a_fast_hold: assert property (
    fast_speed_enable && !standard_reset && por_b && $past(rst_b) && $past(por_b) |=>
    fast_speed_enable) else $error("fast speed cleared");
  a_fast_clear: assert property (
    standard_reset && !wr_en && !scratch_complete |=> !fast_speed_enable)
    else $error("fast speed kept");
  a_lock_hold: assert property (
    write_protect && por_b |=> write_protect) else $error("lock cleared");
  a_lock_reject: assert property (
    write_protect && cfg1_wr |=> protected_write_rejected && $stable(device_config_one))
    else $error("locked write taken");
  a_src_change: assert property (
    address_source_changed |-> $past(short_address_source) != $past(short_address_source, 2))
    else $error("spurious change");
  a_oneshot_run: assert property (
    s_launch |-> s_running) else $error("one-shot did not start");
  a_done_pulse: assert property (
    conversion_done |=> !conversion_done) else $error("done not a pulse");
endmodule
bind sensor_config_registers sensor_config_registers_chk u_chk (
  .clk_sys                    (clk_sys),
  .rst_b                      (rst_b),
  .por_b                      (por_b),
  .wr_en                      (wr_en),
  .wr_addr                    (wr_addr),
  .wr_data                    (wr_data),
  .standard_reset             (standard_reset),
  .scratch_complete           (scratch_complete),
  .convert_cmd                (convert_cmd),
  .bus_powered_pin            (bus_powered_pin),
  .device_config_one          (device_config_one),
  .result_format_select       (result_format_select),
  .alert_comparator_mode      (alert_comparator_mode),
  .averaging_select           (averaging_select),
  .conversion_schedule_select (conversion_schedule_select),
  .fast_speed_enable          (fast_speed_enable),
  .short_address_source       (short_address_source),
  .address_source_changed     (address_source_changed),
  .write_protect              (write_protect),
  .protected_write_rejected   (protected_write_rejected),
  .conversion_start           (conversion_start),
  .conversion_busy            (conversion_busy),
  .conversion_done            (conversion_done)
);

// [sim/sensor_config_registers_tb.sv]
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model drives the write side
// Notes:   Conversion counts shortened through parameters
`timescale 1ns/100ps
module sensor_config_registers_tb;
  import sensor_cfg_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG  = 40;
  localparam int PERIOD = 100;
  logic       clk_sys, rst_b, por_b, bus_powered_pin, wr_en, copy_cmd, convert_cmd;
  logic       scratch_complete, standard_reset, result_format_select, write_protect;
  logic       conversion_duration_select, alert_comparator_mode, averaging_select;
  logic       fast_speed_enable, address_source_changed, protected_write_rejected;
  logic       conversion_start, conversion_busy, conversion_done;
  logic [7:0] short_address, wr_addr, wr_data, device_config_one, device_config_two, c1;
  logic [2:0] conversion_schedule_select;
  logic [1:0] short_address_source;
  int         num_errors = 0;
  int         n_checks = 0;
  int         seed = 89;
  typedef struct {string nm; int sel; logic [7:0] val;} note_t;
  note_t      notes[$];
  event       ev;
  sensor_config_registers #(.CONV_SHORT_CYCLES(SHORT), .CONV_LONG_CYCLES(LONG),
    .PERIOD_MIN_CYCLES(PERIOD)) uut (.*);
  host_model u_host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] view(input int s);
    if (s == 0) return device_config_one;
    if (s == 1) return device_config_two;
    return {result_format_select, conversion_duration_select, alert_comparator_mode,
      averaging_select, fast_speed_enable, write_protect, protected_write_rejected, 1'b0};
  endfunction
  function automatic logic [7:0] fields(input logic [7:0] c, input logic f, l, r);
    return {c[7], c[5], c[4] & ~bus_powered_pin, c[3], f, l, r, 1'b0};
  endfunction
  task automatic expect_val(input string nm, input int s, input logic [7:0] v);
    notes.push_back('{nm, s, v});
    #1 -> ev;
  endtask
  // Monitor takes the oldest note so checks never pair with the wrong result
  always @(ev) begin
    note_t n;
    n = notes.pop_front();
    n_checks++;
    if (view(n.sel) !== n.val) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n.nm, n.val, view(n.sel));
    end
  end
  task automatic do_reset(input logic power_on);
    rst_b = 1'b0;
    por_b = ~power_on;
    repeat (5) @(posedge clk_sys);
    #1 por_b = 1'b1;
    @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic conv_time(input int want);
    int t;
    t = 0;
    u_host.strobe(3);
    while (conversion_done !== 1'b1 && t < 5000) begin
      @(posedge clk_sys);
      #1 t++;
    end
    n_checks++;
    if (t < want - 3 || t > want + 3) begin
      num_errors++;
      $display("[ERR] conv_cycles expected %0d seen %0d", want, t);
    end
  endtask
  // First pass finds a start, second counts edges to the next one
  task automatic per_time(input int want);
    int t;
    t = 0;
    for (int k = 0; k < 2; k++) begin
      t = 0;
      @(posedge clk_sys);
      #1 t++;
      while (conversion_start !== 1'b1 && t < 5000) begin
        @(posedge clk_sys);
        #1 t++;
      end
    end
    n_checks++;
    if (t < want - 3 || t > want + 3) begin
      num_errors++;
      $display("[ERR] period_cycles expected %0d seen %0d", want, t);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish;
  end
  initial begin
    bus_powered_pin = 1'b1;
    short_address = 8'h02;
    do_reset(1'b1);
    expect_val("cfg_one", 0, RST_CONFIG_ONE);
    expect_val("cfg_two", 1, RST_CONFIG_TWO);
    $display("Test reset done");
    for (int i = 0; i < 12; i++) begin
      bus_powered_pin = i[0];
      c1 = 8'($random(seed));
      if (bus_powered_pin && c1[2:0] > 3'h2) c1[2:0] = 3'h2;
      u_host.wr(OFS_CONFIG_ONE, c1);
      expect_val("cfg_one", 0, c1 | 8'h40);
      expect_val("fields", 2, fields(c1, 1'b1, 1'b0, 1'b0));
    end
    $display("Test fields done");
    u_host.wr(OFS_CONFIG_TWO, 8'h00);
    expect_val("fast_hold", 1, 8'h80);
    u_host.strobe(2);
    expect_val("fast_clear", 1, 8'h00);
    $display("Test fast speed done");
    u_host.wr(OFS_CONFIG_TWO, 8'h5e);
    u_host.wr(OFS_CONFIG_ONE, 8'h49);
    u_host.strobe(0);
    u_host.wr(OFS_CONFIG_ONE, 8'h40);
    do_reset(1'b0);
    expect_val("restore_one", 0, 8'h49);
    expect_val("restore_two", 1, 8'h1e);
    $display("Test copy done");
    conv_time(int'(short_address) * STAGGER_STEP_CYC + 2 + 8 * (SHORT + 2));
    u_host.wr(OFS_CONFIG_ONE, 8'h60);
    conv_time(LONG + 2);
    u_host.wr(OFS_CONFIG_ONE, 8'h68);
    conv_time(8 * (LONG + 2));
    bus_powered_pin = 1'b0;
    u_host.wr(OFS_CONFIG_ONE, 8'h46);
    per_time(PERIOD * 2);
    $display("Test conversion done");
    u_host.send_scratch(8'h40, 8'h81);
    expect_val("lock_pending", 2, fields(8'h40, 1'b0, 1'b1, 1'b0));
    u_host.strobe(1);
    expect_val("lock_fast", 2, fields(8'h40, 1'b1, 1'b1, 1'b0));
    u_host.wr(OFS_CONFIG_ONE, 8'hff);
    expect_val("blocked", 2, fields(8'h40, 1'b1, 1'b1, 1'b1));
    u_host.wr(OFS_CONFIG_TWO, 8'h00);
    expect_val("lock_sticks", 1, 8'h81);
    $display("Test lock done");
    tally_and_finish;
  end
endmodule
